// *** core/scg_pkg.sv ***
// Package with register map, field layout and reset values for the clock gating block.
package scg_pkg;
   localparam int unsigned SCG_ADDR_W = 12;
   localparam logic [11:0] SCG_OFF_RUN = 12'h100;
   localparam logic [11:0] SCG_OFF_SLEEP = 12'h110;
   localparam logic [11:0] SCG_OFF_DEEP = 12'h120;
   localparam logic [11:0] SCG_OFF_CFG = 12'h060;
   localparam logic [11:0] SCG_OFF_IRQ_STAT = 12'h200;
   localparam logic [11:0] SCG_OFF_IRQ_MASK = 12'h204;
   localparam logic [31:0] SCG_GATE_RESET = 32'h0000_0040;
   localparam logic [31:0] SCG_GATE_MASK = 32'h0001_0348;
   localparam logic [31:0] SCG_DEEP_MASK = 32'h0001_0048;
   localparam int unsigned SCG_BIT_CONV = 16;
   localparam int unsigned SCG_BIT_HIB = 6;
   localparam int unsigned SCG_BIT_TMO = 3;
   localparam int unsigned SCG_RATE_LO = 8;
   localparam int unsigned SCG_RATE_HI = 9;
   localparam int unsigned SCG_BIT_ACG = 27;
   localparam logic [31:0] SCG_CFG_MASK = 32'h0800_0000;
   localparam logic [1:0] SCG_RATE_125K = 2'h0;
   localparam logic [1:0] SCG_RATE_250K = 2'h1;
   localparam logic [1:0] SCG_RATE_500K = 2'h2;
   localparam int unsigned SCG_IRQ_W = 3;
   localparam int unsigned SCG_IRQ_CONV_FAULT = 0;
   localparam int unsigned SCG_IRQ_TMO_FAULT = 1;
   localparam int unsigned SCG_IRQ_BAD_RATE = 2;
   typedef enum logic [2:0] {
      SCG_MODE_RUN = 3'b001,
      SCG_MODE_SLEEP = 3'b010,
      SCG_MODE_DEEP = 3'b100
   } scg_mode_t;
endpackage : scg_pkg

// *** core/scg_gate_reg.sv ***
// One masked gating register with write strobe and reset value.
module scg_gate_reg
   import scg_pkg::*;
#(
   parameter logic [31:0] RESET_VAL = SCG_GATE_RESET,
   parameter logic [31:0] WR_MASK = SCG_GATE_MASK
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_we,
   input wire logic [31:0] i_wdata,
   output logic [31:0] o_value
);
   initial begin
      if ((RESET_VAL & ~WR_MASK) != 32'h0) begin
         $error("Reset value sets bits outside the writable mask.");
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_value <= RESET_VAL;
      end else if (i_we) begin
         o_value <= i_wdata & WR_MASK;
      end
   end
endmodule : scg_gate_reg

// *** core/scg_unit_gate.sv ***
// Glitch-free clock gate for one unit, latch-free flop style on the falling edge.
module scg_unit_gate (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_enable,
   output logic o_unit_clk,
   output logic o_unit_on
);
   logic en_low;

   // The enable is taken on the falling edge and only changes while the clock is low, so the gated clock never gets a runt pulse.
   always_ff @(negedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         en_low <= 1'b0;
      end else begin
         en_low <= i_enable;
      end
   end

   assign o_unit_clk = i_core_clk & en_low;
   assign o_unit_on = i_enable;
endmodule : scg_unit_gate

// *** core/scg_sleep_gating.sv ***
// Sleep-mode clock gating control with APB registers, unit clock gates and access faults.
// How it works
// - each gating bit clocks or stops one unit
// - access to unclocked unit answers bus fault
// - gating bits reset to zero unless noted
// - separate run, sleep and deep-sleep registers
// - sleep registers apply only with auto select
// - sleep register at 0x110, reset 0x00000040
// - bit 16 enables the converter clock
// - bits 9:8 pick converter sample rate
// - bit 6 enables hibernate, resets to one
// - bit 3 enables timeout timer clock
// - unused bits read zero, software preserves them
//
// Chosen here: register access over APB.
module scg_sleep_gating
   import scg_pkg::*;
#(
   parameter logic [1:0] MAX_RATE = SCG_RATE_500K
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_sleep,
   input wire logic i_deep_sleep,
   input wire logic i_conv_access,
   input wire logic i_tmo_access,
   output logic o_conv_fault,
   output logic o_tmo_fault,
   output logic o_conv_clk,
   output logic o_hib_clk,
   output logic o_tmo_clk,
   output logic o_conv_en,
   output logic o_hib_en,
   output logic o_tmo_en,
   output logic [1:0] o_conv_rate,
   output logic o_irq
);
   initial begin
      if (MAX_RATE > SCG_RATE_500K) begin
         $error("MAX_RATE above the highest encoded rate.");
      end
   end

   logic [31:0] run_gate;
   logic [31:0] sleep_gate;
   logic [31:0] deep_gate;
   logic [31:0] cfg;
   logic [SCG_IRQ_W-1:0] irq_stat;
   logic [SCG_IRQ_W-1:0] irq_mask;
   logic [31:0] next_prdata;
   logic conv_fault;
   logic tmo_fault;
   scg_mode_t mode;

   wire write_phase = i_psel && i_penable && i_pwrite;
   wire access_phase = i_psel && i_penable;
   wire hit_run = i_paddr == SCG_OFF_RUN;
   wire hit_sleep = i_paddr == SCG_OFF_SLEEP;
   wire hit_deep = i_paddr == SCG_OFF_DEEP;
   wire hit_cfg = i_paddr == SCG_OFF_CFG;
   wire hit_stat = i_paddr == SCG_OFF_IRQ_STAT;
   wire hit_mask = i_paddr == SCG_OFF_IRQ_MASK;
   wire hit_any = hit_run | hit_sleep | hit_deep | hit_cfg | hit_stat | hit_mask;
   wire auto_gate = cfg[SCG_BIT_ACG];

   // Three independent gating registers, one per power mode.
   scg_gate_reg #(.RESET_VAL(SCG_GATE_RESET), .WR_MASK(SCG_GATE_MASK)) u_run (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_we(write_phase && hit_run),
      .i_wdata(i_pwdata),
      .o_value(run_gate)
   );
   scg_gate_reg #(.RESET_VAL(SCG_GATE_RESET), .WR_MASK(SCG_GATE_MASK)) u_sleep (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_we(write_phase && hit_sleep),
      .i_wdata(i_pwdata),
      .o_value(sleep_gate)
   );
   scg_gate_reg #(.RESET_VAL(SCG_GATE_RESET), .WR_MASK(SCG_DEEP_MASK)) u_deep (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_we(write_phase && hit_deep),
      .i_wdata(i_pwdata),
      .o_value(deep_gate)
   );
   scg_gate_reg #(.RESET_VAL(32'h0), .WR_MASK(SCG_CFG_MASK)) u_cfg (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_we(write_phase && hit_cfg),
      .i_wdata(i_pwdata),
      .o_value(cfg)
   );

   // Mode selection: sleep registers only take over when auto gating is selected.
   always_comb begin
      if (auto_gate && i_deep_sleep) begin
         mode = SCG_MODE_DEEP;
      end else if (auto_gate && i_sleep) begin
         mode = SCG_MODE_SLEEP;
      end else begin
         mode = SCG_MODE_RUN;
      end
   end

   logic [31:0] active_gate;
   always_comb begin
      unique case (mode)
         SCG_MODE_DEEP: active_gate = deep_gate;
         SCG_MODE_SLEEP: active_gate = sleep_gate;
         SCG_MODE_RUN: active_gate = run_gate;
         default: active_gate = run_gate;
      endcase
   end

   assign o_conv_en = active_gate[SCG_BIT_CONV];
   assign o_hib_en = active_gate[SCG_BIT_HIB];
   assign o_tmo_en = active_gate[SCG_BIT_TMO];

   // Sleep with auto gating takes the rate from the sleep register; deep sleep has no rate field.
   wire [1:0] rate_req = (mode == SCG_MODE_SLEEP) ? sleep_gate[SCG_RATE_HI:SCG_RATE_LO] :
      run_gate[SCG_RATE_HI:SCG_RATE_LO];
   wire rate_bad = rate_req > MAX_RATE;
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_conv_rate <= SCG_RATE_125K;
      end else begin
         o_conv_rate <= rate_bad ? MAX_RATE : rate_req;
      end
   end

   scg_unit_gate u_conv_gate (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_enable(o_conv_en),
      .o_unit_clk(o_conv_clk),
      .o_unit_on()
   );
   scg_unit_gate u_hib_gate (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_enable(o_hib_en),
      .o_unit_clk(o_hib_clk),
      .o_unit_on()
   );
   scg_unit_gate u_tmo_gate (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_enable(o_tmo_en),
      .o_unit_clk(o_tmo_clk),
      .o_unit_on()
   );

   // Accesses to a stopped unit are faulted, not forwarded.
   assign conv_fault = i_conv_access && !o_conv_en;
   assign tmo_fault = i_tmo_access && !o_tmo_en;
   assign o_conv_fault = conv_fault;
   assign o_tmo_fault = tmo_fault;

   wire [SCG_IRQ_W-1:0] irq_event = {rate_bad, tmo_fault, conv_fault};
   wire [SCG_IRQ_W-1:0] irq_clr =
      (write_phase && hit_stat) ? i_pwdata[SCG_IRQ_W-1:0] : '0;

   // Set wins over a clear in the same cycle.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_event;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_mask <= '0;
      end else if (write_phase && hit_mask) begin
         irq_mask <= i_pwdata[SCG_IRQ_W-1:0];
      end
   end

   assign o_irq = |(irq_stat & irq_mask);

   // Read mux; unused bits are already zero in every stored value.
   always_comb begin
      next_prdata = 32'h0;
      if (hit_run) begin
         next_prdata = run_gate;
      end else if (hit_sleep) begin
         next_prdata = sleep_gate;
      end else if (hit_deep) begin
         next_prdata = deep_gate;
      end else if (hit_cfg) begin
         next_prdata = cfg;
      end else if (hit_stat) begin
         next_prdata = {{(32 - SCG_IRQ_W){1'b0}}, irq_stat};
      end else if (hit_mask) begin
         next_prdata = {{(32 - SCG_IRQ_W){1'b0}}, irq_mask};
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_prdata <= 32'h0;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         o_prdata <= next_prdata;
      end
   end

   assign o_pready = 1'b1;
   assign o_pslverr = access_phase && !hit_any;
endmodule : scg_sleep_gating

// *** dv/scg_sleep_gating_asserts.sv ***
// Concurrent checks on the ports of the sleep clock gating block.
module scg_sleep_gating_asserts
   import scg_pkg::*;
#(
   parameter logic [1:0] MAX_RATE = SCG_RATE_500K
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic i_sleep,
   input wire logic i_deep_sleep,
   input wire logic i_conv_access,
   input wire logic i_tmo_access,
   input wire logic o_conv_fault,
   input wire logic o_tmo_fault,
   input wire logic o_conv_en,
   input wire logic o_hib_en,
   input wire logic o_tmo_en,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_irq,
   input wire logic [1:0] o_conv_rate
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   wire acc = i_psel && i_penable;
   wire run_wr = acc && i_pwrite && !i_sleep && !i_deep_sleep;
   a_conv_fault: assert property (
      o_conv_fault == (i_conv_access && !o_conv_en)) else $error("conv fault wrong");
   a_tmo_fault: assert property (
      o_tmo_fault == (i_tmo_access && !o_tmo_en)) else $error("timer fault wrong");
   a_zero_wait: assert property (acc |-> o_pready) else $error("pready low");
   a_map_ok: assert property (
      acc && i_paddr == SCG_OFF_SLEEP |-> !o_pslverr) else $error("sleep reg err");
   a_unmapped_err: assert property (
      acc && i_paddr == 12'h00c |-> o_pslverr) else $error("unmapped no err");
   a_rate_cap: assert property (o_conv_rate <= MAX_RATE) else $error("rate cap");
   a_reset_vals: assert property (
      $rose(i_rst_n) |-> o_hib_en && !o_conv_en && !o_tmo_en) else $error("reset enables");
   a_sleep_ignored: assert property (
      run_wr && i_paddr == SCG_OFF_SLEEP |=> $stable({o_conv_en, o_hib_en, o_tmo_en}))
      else $error("sleep reg used in run");
   cover property (o_conv_fault);
   cover property (o_tmo_fault);
   cover property (o_irq);
endmodule : scg_sleep_gating_asserts
bind scg_sleep_gating scg_sleep_gating_asserts #(.MAX_RATE(MAX_RATE)) u_chk (
   .i_core_clk(i_core_clk),
   .i_rst_n(i_rst_n),
   .i_psel(i_psel),
   .i_penable(i_penable),
   .i_pwrite(i_pwrite),
   .i_paddr(i_paddr),
   .i_sleep(i_sleep),
   .i_deep_sleep(i_deep_sleep),
   .i_conv_access(i_conv_access),
   .i_tmo_access(i_tmo_access),
   .o_conv_fault(o_conv_fault),
   .o_tmo_fault(o_tmo_fault),
   .o_conv_en(o_conv_en),
   .o_hib_en(o_hib_en),
   .o_tmo_en(o_tmo_en),
   .o_pready(o_pready),
   .o_pslverr(o_pslverr),
   .o_irq(o_irq),
   .o_conv_rate(o_conv_rate)
);

// *** dv/scg_unit_model.sv ***
// Peripheral-side model that presents one-cycle accesses to the converter and timer.
module scg_unit_model (
   input wire logic i_core_clk,
   input wire logic i_conv_req,
   input wire logic i_tmo_req,
   output logic o_conv_access,
   output logic o_tmo_access
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge i_core_clk) begin
      o_conv_access <= i_conv_req;
      o_tmo_access <= i_tmo_req;
   end
endmodule : scg_unit_model

// *** dv/tb_top.sv ***
// Testbench for the sleep clock gating block: APB sequences with expected values.
module tb_top
   import scg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_core_clk = '0, i_rst_n = '0, i_psel = '0, i_penable = '0, i_pwrite = '0;
   logic i_sleep = '0, i_deep_sleep = '0, conv_req = '0, tmo_req = '0;
   logic [11:0] i_paddr = '0;
   logic [31:0] i_pwdata = '0, o_prdata, rd_val;
   logic o_pready, o_pslverr, i_conv_access, i_tmo_access, o_conv_fault, o_tmo_fault;
   logic o_conv_clk, o_hib_clk, o_tmo_clk, o_conv_en, o_hib_en, o_tmo_en, o_irq, bus_err;
   logic [1:0] o_conv_rate;
   int err_count = 0;
   int n_compared = 0;
   always #10 i_core_clk = ~i_core_clk;
   scg_sleep_gating dut (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sleep(i_sleep),
      .i_deep_sleep(i_deep_sleep), .i_conv_access(i_conv_access),
      .i_tmo_access(i_tmo_access), .o_conv_fault(o_conv_fault), .o_tmo_fault(o_tmo_fault),
      .o_conv_clk(o_conv_clk), .o_hib_clk(o_hib_clk), .o_tmo_clk(o_tmo_clk),
      .o_conv_en(o_conv_en), .o_hib_en(o_hib_en), .o_tmo_en(o_tmo_en),
      .o_conv_rate(o_conv_rate), .o_irq(o_irq)
   );
   scg_unit_model u_units (.i_core_clk(i_core_clk), .i_conv_req(conv_req), .i_tmo_req(tmo_req),
      .o_conv_access(i_conv_access), .o_tmo_access(i_tmo_access));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_core_clk);
      i_penable <= 1'b1;
      do @(posedge i_core_clk); while (o_pready !== 1'b1);
      rd_val = o_prdata;
      bus_err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : xfer
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, '0);
      chk(rd_val, e);
   endtask : rd
   task automatic en(input logic [2:0] e);
      #1 chk({o_conv_en, o_hib_en, o_tmo_en}, e);
      // The gated clocks follow half a cycle later, so look in the next high phase.
      @(posedge i_core_clk);
      #1 chk({o_conv_clk, o_hib_clk, o_tmo_clk}, e);
   endtask : en
   task automatic poke(input logic c, input logic t, input logic [1:0] e);
      @(posedge i_core_clk);
      conv_req <= c;
      tmo_req <= t;
      @(posedge i_core_clk);
      conv_req <= 1'b0;
      tmo_req <= 1'b0;
      #1 chk({o_conv_fault, o_tmo_fault}, e);
   endtask : poke
   task automatic end_sim;
      if (err_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   initial begin
      #100000;
      err_count++;
      end_sim();
   end
   initial begin
      repeat (10) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      en(3'b010);
      rd(SCG_OFF_SLEEP, 32'h0000_0040);
      rd(SCG_OFF_DEEP, 32'h0000_0040);
      xfer(1'b1, SCG_OFF_SLEEP, '1);
      rd(SCG_OFF_SLEEP, 32'h0001_0348);
      rd(12'h00c, '0);
      chk(bus_err, 1'b1);
      for (int r = 0; r < 4; r++) begin
         xfer(1'b1, SCG_OFF_RUN, 32'h0000_0040 | (r << 8));
         // The rate output is registered, so it follows one edge after the write.
         @(posedge i_core_clk);
         #1 chk(o_conv_rate, (r > SCG_RATE_500K) ? SCG_RATE_500K : r);
      end
      xfer(1'b1, SCG_OFF_RUN, 32'h0000_0040);
      i_sleep <= 1'b1;
      xfer(1'b1, SCG_OFF_SLEEP, 32'h0001_0148);
      en(3'b010);
      chk(o_conv_rate, SCG_RATE_125K);
      xfer(1'b1, SCG_OFF_CFG, 32'h0800_0000);
      en(3'b111);
      chk(o_conv_rate, SCG_RATE_250K);
      poke(1'b1, 1'b1, 2'b00);
      xfer(1'b1, SCG_OFF_SLEEP, '0);
      en(3'b000);
      poke(1'b1, 1'b0, 2'b10);
      poke(1'b0, 1'b1, 2'b01);
      #1 chk(o_irq, 1'b0);
      xfer(1'b1, SCG_OFF_IRQ_MASK, 32'h0000_0007);
      rd(SCG_OFF_IRQ_STAT, 32'h0000_0007);
      #1 chk(o_irq, 1'b1);
      xfer(1'b1, SCG_OFF_IRQ_STAT, 32'h0000_0007);
      i_deep_sleep <= 1'b1;
      rd(SCG_OFF_IRQ_STAT, '0);
      #1 chk(o_irq, 1'b0);
      en(3'b010);
      end_sim();
   end
endmodule : tb_top
